// [rtl/drg_pkg.sv]
/*
 reset and gain control package: frame layout, command codes, keys,
 clear codes and power-on timing for the eight-channel converter.
 assumes a 24-bit serial frame, msb first, acted on at sync rise.
*/
package drg_pkg;
	localparam int NUM_CH      = 8;
	localparam int FRAME_BITS  = 24;
	localparam int CODE_W      = 16;
	localparam int CMD_HI      = 23;
	localparam int CMD_LO      = 20;
	localparam int ADDR_HI     = 19;
	localparam int ADDR_LO     = 16;
	localparam int DATA_HI     = 15;
	localparam int DATA_LO     = 0;
	localparam int GAIN_POS    = 2;
	localparam int RSV_HI      = 1;
	localparam int RSV_LO      = 0;

	localparam logic [3:0]  CMD_WRITE_IN   = 4'h1;
	localparam logic [3:0]  CMD_UPDATE     = 4'h2;
	localparam logic [3:0]  CMD_WRITE_UPD  = 4'h3;
	localparam logic [3:0]  CMD_SOFT_RESET = 4'h6;
	localparam logic [3:0]  CMD_GAIN_SETUP = 4'h7;
	localparam logic [3:0]  SOFT_RESET_ADDR = 4'h0;
	localparam logic [15:0] SOFT_RESET_KEY  = 16'h1234;

	localparam logic [15:0] ZERO_SCALE = 16'h0000;
	localparam logic [15:0] MID_SCALE  = 16'h8000;
	localparam logic [2:0]  GAIN_RESET = 3'h0;

	// power-on reset sequence length
	localparam int CLK_MHZ      = 40;
	localparam int POR_TIME_US  = 10;
	localparam int POR_CYCLES   = POR_TIME_US * CLK_MHZ;
	localparam int POR_CNT_W    = 12;

	typedef struct packed {
		logic [3:0]  cmd;
		logic [3:0]  addr;
		logic [15:0] data;
	} drg_frame_t;

	typedef enum logic [1:0] {
		DRG_POR      = 2'b00,
		DRG_WAIT_RST = 2'b01,
		DRG_RUN      = 2'b10
	} drg_state_t;
endpackage

// [rtl/drg_core.sv]
/*
 reset and gain control of an eight-channel serial converter: serial
 frame capture on the link clock, hand-over on synced sync rise, hardware
 clear, power-up level select, software reset and gain setup.
 assumes the host sends 24-bit frames framed by sync_n; pins are async.
*/
// Notes on behaviour
// - reset low clears outputs to clear code
// - after reset release outputs stay cleared
// - no output update while reset held low
// - ignore strobe and reset during power-on
// - reset low at power-up stalls init
// - level select picks zero or midscale
// - power-up level held until valid write
// - without select pin outputs start zero
// - command 0110 performs software reset
// - software reset needs address 0, key 1234
// - gain bit clear gives 1, set 2
// - gain frame layout, reserved bits zero
`timescale 1ns/100ps
module drg_core #(
	parameter bit          HAS_LEVEL_SELECT = 1'b1,
	parameter int unsigned POR_LEN          = drg_pkg::POR_CYCLES
) (
	// system
	input  wire logic                      sys_clk,
	input  wire logic                      rst,
	// serial link
	input  wire logic                      link_clk,
	input  wire logic                      sync_n,
	input  wire logic                      link_din,
	// pins
	input  wire logic                      hw_reset_n,
	input  wire logic                      load_strobe_n,
	input  wire logic                      power_up_level_select,
	// converter side
	output logic [drg_pkg::CODE_W-1:0]     dac_code [drg_pkg::NUM_CH],
	output logic                           gain_two,
	output logic                           init_done
);
	import drg_pkg::*;

	// ---------------------------------------------------------------
	// link domain: frame capture
	// ---------------------------------------------------------------
	logic [FRAME_BITS-1:0] shift;
	logic [4:0]            bit_cnt;
	logic [FRAME_BITS-1:0] frame_hold;
	logic                  frame_ok;
	logic                  in_frame;

	// frame flag drops as soon as sync goes high, so the first rise
	// of every frame restarts the bit count from a known state
	always_ff @(posedge link_clk or posedge sync_n) begin
		if (sync_n) begin
			in_frame <= 1'b0;
		end else begin
			in_frame <= 1'b1;
		end
	end

	always_ff @(posedge link_clk) begin
		if (!sync_n) begin
			shift   <= {shift[FRAME_BITS-2:0], link_din};
			bit_cnt <= in_frame ? bit_cnt + 5'h1 : 5'h1;
		end
	end

	// word and length taken at sync rise; both stand still until the
	// next rise, which leaves the sys side time to copy them
	always_ff @(posedge sync_n) begin
		frame_hold <= shift;
		frame_ok   <= in_frame && bit_cnt == 5'(FRAME_BITS);
	end

	// ---------------------------------------------------------------
	// crossing into sys_clk
	// ---------------------------------------------------------------
	logic [1:0] sn_sync;
	logic       sn_prev;
	logic       sn_rise;
	logic [1:0] rst_sync;
	logic [1:0] ld_sync;
	logic [1:0] sel_sync;
	logic       ld_prev;
	logic       frame_evt;
	drg_frame_t frm;

	always_ff @(posedge sys_clk) begin
		rst_sync <= {rst_sync[0], hw_reset_n};
		ld_sync  <= {ld_sync[0], load_strobe_n};
		sel_sync <= {sel_sync[0], power_up_level_select};
		ld_prev  <= ld_sync[1];
	end

	// sync idles high; reset to that level so no false rise follows
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sn_sync   <= 2'b11;
			sn_prev   <= 1'b1;
			frame_evt <= 1'b0;
		end else begin
			sn_sync   <= {sn_sync[0], sync_n};
			sn_prev   <= sn_sync[1];
			frame_evt <= sn_rise && frame_ok;
		end
	end

	assign sn_rise = sn_sync[1] && !sn_prev;

	// copy of the held word, valid in the cycle frame_evt is high
	always_ff @(posedge sys_clk) begin
		if (sn_rise) begin
			frm <= drg_frame_t'(frame_hold);
		end
	end

	function automatic logic is_cmd(drg_frame_t f, logic [3:0] c);
		return f.cmd == c;
	endfunction

	// ---------------------------------------------------------------
	// power-on sequence
	// ---------------------------------------------------------------
	drg_state_t             state;
	logic [POR_CNT_W-1:0]   por_cnt;
	logic                   running;
	logic                   hw_clear;
	logic [CODE_W-1:0]      clear_code;

	assign running  = (state == DRG_RUN);
	assign hw_clear = running && !rst_sync[1];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state   <= DRG_POR;
			por_cnt <= '0;
		end else begin
			case (state)
				DRG_POR: begin
					// strobe and reset pins ignored while counting
					if (por_cnt == POR_CNT_W'(POR_LEN - 1)) begin
						state <= DRG_WAIT_RST;
					end else begin
						por_cnt <= por_cnt + 1'b1;
					end
				end
				DRG_WAIT_RST: begin
					if (rst_sync[1]) begin
						state <= DRG_RUN;
					end
				end
				default: state <= DRG_RUN;
			endcase
		end
	end

	// clear code follows the select pin during the power-on count and is held once the count ends
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			clear_code <= ZERO_SCALE;
		end else if (state == DRG_POR) begin
			clear_code <= (HAS_LEVEL_SELECT && sel_sync[1])
			              ? MID_SCALE : ZERO_SCALE;
		end
	end

	// ---------------------------------------------------------------
	// frame decode
	// ---------------------------------------------------------------
	logic soft_reset;
	logic gain_wr;
	logic ld_fall;

	assign soft_reset = running && frame_evt
	                    && is_cmd(frm, CMD_SOFT_RESET)
	                    && frm.addr == SOFT_RESET_ADDR
	                    && frm.data == SOFT_RESET_KEY;
	assign gain_wr    = running && frame_evt && rst_sync[1]
	                    && is_cmd(frm, CMD_GAIN_SETUP)
	                    && frm.data[RSV_HI:RSV_LO] == 2'h0;
	assign ld_fall    = running && ld_prev && !ld_sync[1];

	// ---------------------------------------------------------------
	// input and output code registers
	// ---------------------------------------------------------------
	logic [CODE_W-1:0] in_reg [NUM_CH];
	logic              wr_in;
	logic              wr_upd;
	logic              upd_one;
	logic [2:0]        ch;

	assign ch      = frm.addr[2:0];
	assign wr_in   = running && frame_evt && rst_sync[1]
	                 && (is_cmd(frm, CMD_WRITE_IN)
	                 || is_cmd(frm, CMD_WRITE_UPD));
	assign upd_one = running && frame_evt && rst_sync[1]
	                 && (is_cmd(frm, CMD_UPDATE)
	                 || is_cmd(frm, CMD_WRITE_UPD)
	                 || (is_cmd(frm, CMD_WRITE_IN) && !ld_sync[1]));
	assign wr_upd  = upd_one;

	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < NUM_CH; i++) begin
			if (rst || state != DRG_RUN || hw_clear || soft_reset) begin
				in_reg[i] <= clear_code;
			end else if (wr_in && ch == 3'(i)) begin
				in_reg[i] <= frm.data;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < NUM_CH; i++) begin
			if (rst) begin
				dac_code[i] <= ZERO_SCALE;
			end else if (state != DRG_RUN) begin
				dac_code[i] <= clear_code;
			end else if (hw_clear || soft_reset) begin
				dac_code[i] <= clear_code;
			end else if (wr_upd && ch == 3'(i)) begin
				dac_code[i] <= wr_in ? frm.data : in_reg[i];
			end else if (ld_fall && rst_sync[1]) begin
				dac_code[i] <= in_reg[i];
			end
		end
	end

	// ---------------------------------------------------------------
	// gain setup
	// ---------------------------------------------------------------
	logic [2:0] gain_reg;

	always_ff @(posedge sys_clk) begin
		if (rst || soft_reset) begin
			gain_reg <= GAIN_RESET;
		end else if (gain_wr) begin
			gain_reg <= frm.data[2:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gain_two  <= 1'b0;
			init_done <= 1'b0;
		end else begin
			gain_two  <= gain_reg[GAIN_POS];
			init_done <= running;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_clear_holds: assert property (@(posedge sys_clk) disable iff (rst)
		hw_clear |=> dac_code[0] == clear_code)
		else $error("output not cleared under reset");
	a_no_upd_low: assert property (@(posedge sys_clk) disable iff (rst)
		(running && !rst_sync[1] && $past(!rst_sync[1]))
		|-> $stable(dac_code[1]) || dac_code[1] == clear_code)
		else $error("output changed while reset low");
	a_por_quiet: assert property (@(posedge sys_clk) disable iff (rst)
		(state == DRG_POR) |-> !ld_fall && !hw_clear)
		else $error("pin acted on during power-on");
	a_wait_rst: assert property (@(posedge sys_clk) disable iff (rst)
		(state == DRG_WAIT_RST && !rst_sync[1]) |=> !running)
		else $error("init finished with reset low");
	a_soft_key: assert property (@(posedge sys_clk) disable iff (rst)
		soft_reset |-> frm.data == 16'h1234 && frm.addr == 4'h0)
		else $error("soft reset without key");
	a_soft_clear: assert property (@(posedge sys_clk) disable iff (rst)
		soft_reset |=> dac_code[0] == clear_code ##1 !gain_two)
		else $error("soft reset did not restore code");
	a_gain_bit: assert property (@(posedge sys_clk) disable iff (rst)
		gain_wr |=> ##1 gain_two == $past(frm.data[2], 2))
		else $error("gain bit not applied");
	a_bad_key: assert property (@(posedge sys_clk) disable iff (rst)
		(running && frame_evt && is_cmd(frm, CMD_SOFT_RESET)
		 && frm.data != SOFT_RESET_KEY && rst_sync[1])
		|=> $stable(dac_code[2]))
		else $error("bad key changed output");
	a_rst_zero: assert property (@(posedge sys_clk)
		rst |=> dac_code[3] == ZERO_SCALE && !gain_two && !init_done)
		else $error("outputs not zero under system reset");
	a_por_level: assert property (@(posedge sys_clk) disable iff (rst)
		!running |=> dac_code[5] == $past(clear_code))
		else $error("output left power-up level before run");
	a_level_mid: assert property (@(posedge sys_clk) disable iff (rst)
		(state == DRG_POR && HAS_LEVEL_SELECT && sel_sync[1])
		|=> clear_code == MID_SCALE)
		else $error("select high did not give midscale");
	a_level_zero: assert property (@(posedge sys_clk) disable iff (rst)
		(state == DRG_POR && !(HAS_LEVEL_SELECT && sel_sync[1]))
		|=> clear_code == ZERO_SCALE)
		else $error("clear code not zero scale");
	a_held_clear: assert property (@(posedge sys_clk) disable iff (rst)
		(running && $past(hw_clear) && !frame_evt && !ld_fall)
		|=> dac_code[6] == clear_code)
		else $error("output left clear code without write");
	a_hold_power: assert property (@(posedge sys_clk) disable iff (rst)
		(running && !frame_evt && !ld_fall && !hw_clear)
		|=> $stable(dac_code[7]))
		else $error("output moved without a write");
	a_rst_no_wr: assert property (@(posedge sys_clk) disable iff (rst)
		(running && !rst_sync[1]) |-> !wr_in && !upd_one)
		else $error("write accepted while reset low");
	a_clear_all: assert property (@(posedge sys_clk) disable iff (rst)
		hw_clear |=> dac_code[7] == clear_code
		&& dac_code[4] == clear_code)
		else $error("channel not cleared under reset");
	a_gain_rsv: assert property (@(posedge sys_clk) disable iff (rst)
		(running && frame_evt && is_cmd(frm, CMD_GAIN_SETUP)
		 && frm.data[RSV_HI:RSV_LO] != 2'h0)
		|=> $stable(gain_reg))
		else $error("gain frame with reserved bits applied");
	a_gain_hold: assert property (@(posedge sys_clk) disable iff (rst)
		(!gain_wr && !soft_reset) |=> $stable(gain_reg))
		else $error("gain changed without gain frame");
	a_sw_gain: assert property (@(posedge sys_clk) disable iff (rst)
		soft_reset |=> gain_reg == GAIN_RESET)
		else $error("soft reset left gain set");
	a_evt_pulse: assert property (@(posedge sys_clk) disable iff (rst)
		frame_evt |=> !frame_evt)
		else $error("one frame acted on twice");
	a_init_track: assert property (@(posedge sys_clk) disable iff (rst)
		1'b1 |=> init_done == $past(running))
		else $error("init flag does not follow run state");
	a_run_stays: assert property (@(posedge sys_clk) disable iff (rst)
		running |=> running)
		else $error("left run state without reset");
	a_upd_data: assert property (@(posedge sys_clk) disable iff (rst)
		(wr_in && upd_one && ch == 3'h2 && !hw_clear && !soft_reset)
		|=> dac_code[2] == $past(frm.data))
		else $error("written code not on output");
	a_load_fall: assert property (@(posedge sys_clk) disable iff (rst)
		(ld_fall && rst_sync[1] && !frame_evt)
		|=> dac_code[5] == $past(in_reg[5]))
		else $error("load strobe did not update output");
	a_clear_wait: assert property (@(posedge sys_clk) disable iff (rst)
		(running && !rst_sync[1]) |=> dac_code[1] == clear_code)
		else $error("output not at clear code while reset low");
endmodule

// [test/drg_host_model.sv]
/*
 host serial port model: sends frames msb first, up to 24 bits.
 assumes the design samples link_din on the link_clk rise.
*/
`timescale 1ns/100ps
module drg_host_model (
	// serial link
	output logic link_clk,
	output logic sync_n,
	output logic link_din
);
	initial begin
		link_clk = 1'b0;
		sync_n   = 1'b1;
		link_din = 1'b0;
	end

	// clock runs only inside a frame, 30 ns period
	task automatic send(input logic [23:0] w, input int n);
		sync_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			link_din = w[i];
			#15 link_clk = 1'b1;
			#15 link_clk = 1'b0;
		end
		#15 sync_n = 1'b1;
		// released line shows no stale bit
		link_din = ~link_din;
	endtask
endmodule

// [test/testbench.sv]
/*
 testbench of the reset and gain control block.
 assumes POR_LEN of 8 and the host model on the serial link.
*/
`timescale 1ns/100ps
module testbench;
	import drg_pkg::*;
	localparam int POR = 8;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        hw_reset_n = 1'b0;
	logic        load_strobe_n = 1'b1;
	logic        power_up_level_select = 1'b1;
	logic        link_clk, sync_n, link_din;
	logic [15:0] dac_code [NUM_CH];
	logic        gain_two, init_done;
	int          fails = 0;
	int          n_checks = 0;

	always #12.5 sys_clk = ~sys_clk;

	drg_host_model host (.link_clk(link_clk), .sync_n(sync_n),
		.link_din(link_din));
	drg_core #(.HAS_LEVEL_SELECT(1'b1), .POR_LEN(POR)) dut (
		.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
		.sync_n(sync_n), .link_din(link_din), .hw_reset_n(hw_reset_n),
		.load_strobe_n(load_strobe_n),
		.power_up_level_select(power_up_level_select),
		.dac_code(dac_code), .gain_two(gain_two), .init_done(init_done));

	task automatic conclude();
		if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic chk_all(input logic [15:0] exp);
		for (int c = 0; c < NUM_CH; c++) chk(dac_code[c], exp);
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic send(input logic [23:0] w);
		host.send(w, 24);
		tick(8);
	endtask

	task automatic t_power_up();
		tick(3);
		rst = 1'b0;
		load_strobe_n = 1'b0;
		tick(2);
		load_strobe_n = 1'b1;
		tick(POR + 8);
		chk({15'h0, init_done}, 16'h0);
		chk_all(MID_SCALE);
		hw_reset_n = 1'b1;
		tick(6);
		chk({15'h0, init_done}, 16'h1);
	endtask

	task automatic t_write();
		send({CMD_WRITE_UPD, 4'h2, 16'h1234});
		chk(dac_code[2], 16'h1234);
		chk(dac_code[1], MID_SCALE);
		host.send({CMD_WRITE_UPD, 4'h3, 16'h00ff}, 23);
		tick(8);
		chk(dac_code[3], MID_SCALE);
		send({CMD_WRITE_IN, 4'h5, 16'h0abc});
		chk(dac_code[5], MID_SCALE);
		load_strobe_n = 1'b0;
		tick(4);
		load_strobe_n = 1'b1;
		chk(dac_code[5], 16'h0abc);
	endtask

	task automatic t_clear();
		hw_reset_n = 1'b0;
		tick(6);
		chk_all(MID_SCALE);
		send({CMD_WRITE_IN, 4'h0, 16'h00aa});
		load_strobe_n = 1'b0;
		tick(4);
		load_strobe_n = 1'b1;
		send({CMD_WRITE_UPD, 4'h1, 16'h5555});
		chk_all(MID_SCALE);
		hw_reset_n = 1'b1;
		tick(8);
		chk_all(MID_SCALE);
	endtask

	task automatic t_soft();
		send({CMD_WRITE_UPD, 4'h4, 16'h0f0f});
		send({CMD_SOFT_RESET, 4'h1, SOFT_RESET_KEY});
		chk(dac_code[4], 16'h0f0f);
		send({CMD_SOFT_RESET, SOFT_RESET_ADDR, 16'h1235});
		chk(dac_code[4], 16'h0f0f);
		send({CMD_SOFT_RESET, SOFT_RESET_ADDR, SOFT_RESET_KEY});
		chk_all(MID_SCALE);
	endtask

	task automatic t_gain();
		chk({15'h0, gain_two}, 16'h0);
		send(24'h700004);
		chk({15'h0, gain_two}, 16'h1);
		send(24'h700001);
		chk({15'h0, gain_two}, 16'h1);
		send(24'h7ffff8);
		chk({15'h0, gain_two}, 16'h0);
	endtask

	// second reset with the select pin low
	task automatic t_zero();
		power_up_level_select = 1'b0;
		rst = 1'b1;
		tick(3);
		rst = 1'b0;
		tick(POR + 10);
		chk_all(ZERO_SCALE);
		chk({15'h0, init_done}, 16'h1);
	endtask

	initial begin
		@(negedge sys_clk);
		t_power_up();
		t_write();
		t_clear();
		t_soft();
		t_gain();
		t_zero();
		conclude();
	end

	initial begin
		#100us;
		fails++;
		conclude();
	end
endmodule
